// *** rtl/cwl_map.vh ***
`ifndef CWL_MAP_VH
`define CWL_MAP_VH

// ****************************************************************
// Configuration space addressing.
// ****************************************************************
`define CWL_CFG_BASE 24'hF80000
`define CWL_CFG_SPACE_LO 24'h800000
`define CWL_CFG_SPACE_HI 24'hFFFFFF
`define CWL_WORD1_ADDR 24'h00ABFE
`define CWL_WORD2_ADDR 24'h00ABFC
`define CWL_WORD_STEP 24'h000002

// ****************************************************************
// Configuration word one field positions.
// ****************************************************************
`define CWL_UPPER_HI 23
`define CWL_UPPER_LO 16
`define CWL_RSVD_BIT 15
`define CWL_SCAN_BIT 14
`define CWL_CODEPROT_BIT 13
`define CWL_WRPROT_BIT 12
`define CWL_DEBUG_BIT 11
`define CWL_PAIR_HI 9
`define CWL_PAIR_LO 8
`define CWL_WDT_EN_BIT 7
`define CWL_WIN_DIS_BIT 6
`define CWL_UNIMP_BIT 5
`define CWL_PRESCALE_BIT 4
`define CWL_POST_HI 3
`define CWL_POST_LO 0

// ****************************************************************
// Reset values and encodings.
// ****************************************************************
`define CWL_ERASED_WORD 24'hFFFFFF
`define CWL_PAIR_ONE 2'h3
`define CWL_PAIR_TWO 2'h2
`define CWL_PAIR_THREE 2'h1
`define CWL_PAIR_RSVD 2'h0
`define CWL_PRESCALE_LONG 8'h80
`define CWL_PRESCALE_SHORT 8'h20

// ****************************************************************
// Timing: flash read latency in cycles.
// ****************************************************************
`define CWL_FLASH_LAT 4'h2

`endif

// *** rtl/cwl_decode.v ***
`timescale 1ns/10ps
`default_nettype none
`include "cwl_map.vh"

// ****************************************************************
// Field decoder for configuration word one.
// ****************************************************************
module cwl_decode (
  // Packed word
  input wire [23:0] word,
  // Decoded fields
  output wire scan_en,
  output wire code_prot_n,
  output wire write_prot_n,
  output wire run_mode,
  output wire [1:0] pair_sel,
  output wire pair_rsvd,
  output wire wdt_en,
  output wire win_dis,
  output wire [7:0] prescale_ratio,
  output wire [3:0] post_sel,
  output wire [15:0] post_ratio_log
);

  // Straight bit picks, save pair_rsvd, prescale_ratio and post_ratio_log; a 1 is the erased choice.
  // boundary-scan enable pick
  assign scan_en = word[`CWL_SCAN_BIT];
  assign code_prot_n = word[`CWL_CODEPROT_BIT];
  assign write_prot_n = word[`CWL_WRPROT_BIT];
  assign run_mode = word[`CWL_DEBUG_BIT];
  assign pair_sel = word[`CWL_PAIR_HI:`CWL_PAIR_LO];
  assign pair_rsvd = (pair_sel == `CWL_PAIR_RSVD);
  assign wdt_en = word[`CWL_WDT_EN_BIT];
  assign win_dis = word[`CWL_WIN_DIS_BIT];
  assign prescale_ratio = word[`CWL_PRESCALE_BIT] ? `CWL_PRESCALE_LONG : `CWL_PRESCALE_SHORT;
  assign post_sel = word[`CWL_POST_HI:`CWL_POST_LO];
  assign post_ratio_log = 16'h0001 << post_sel;

endmodule // cwl_decode

`default_nettype wire

// *** rtl/cwl_loader.v ***
`timescale 1ns/10ps
`default_nettype none
`include "cwl_map.vh"


module cwl_loader (
  // Clock and reset
  input wire core_clk,
  input wire reset,
  // Device reset request of any kind
  input wire dev_reset_req,
  // Flash read port
  output reg flash_rd_en,
  output reg [23:0] flash_addr,
  input wire [23:0] flash_rdata,
  input wire flash_rvalid,
  // Table read into configuration space
  input wire tbl_rd_en,
  input wire [23:0] tbl_addr,
  output reg [23:0] tbl_rdata,
  output reg tbl_hit,
  // Core release
  output wire core_reset_hold,
  // Decoded configuration
  output wire boundary_scan_port_enable,
  output wire general_code_protect_n,
  output wire general_write_protect_n,
  output wire debug_mode_n,
  output wire [1:0] emulator_pin_pair_select,
  output wire emulator_pair_reserved,
  output wire watchdog_enable_cfg,
  output wire window_mode_disable,
  output wire window_mode_active,
  output wire [7:0] watchdog_prescale_ratio,
  output wire [3:0] watchdog_postscale_select,
  output wire [15:0] watchdog_postscale_log
);

  // ****************************************************************
  // States.
  // ****************************************************************
  localparam [3:0] ST_FETCH1 = 4'h1;
  localparam [3:0] ST_WAIT1 = 4'h2;
  localparam [3:0] ST_WAIT2 = 4'h4;
  localparam [3:0] ST_DONE = 4'h8;

  reg [3:0] state_q;
  reg [3:0] state_d;
  reg [23:0] word_one_q;
  reg [23:0] word_two_q;
  reg [23:0] flash_config_word_one;
  wire [23:0] active_word;
  wire [23:0] shown_word;
  wire in_cfg_space;

  // Forces the fixed bits so the stored word reads as documented.
  function [23:0] cwl_clean;
    input [23:0] raw;
    begin
      cwl_clean = raw;
      cwl_clean[`CWL_UPPER_HI:`CWL_UPPER_LO] = 8'hFF;
      cwl_clean[`CWL_UNIMP_BIT] = 1'b1;
    end
  endfunction

  // ****************************************************************
  // Load sequencer.
  // ****************************************************************

  // Next state: request word one, then word two, then hold.
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_FETCH1: state_d = ST_WAIT1;
      ST_WAIT1: begin
        if (flash_rvalid) begin
          state_d = ST_WAIT2;
        end
      end
      ST_WAIT2: begin
        if (flash_rvalid) begin
          state_d = ST_DONE;
        end
      end
      ST_DONE: state_d = ST_DONE;
      default: state_d = ST_FETCH1;
    endcase
  end

  // State and stored words; any reset request restarts the copy.
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_q <= ST_FETCH1;
      word_one_q <= `CWL_ERASED_WORD;
      word_two_q <= `CWL_ERASED_WORD;
      flash_rd_en <= 1'b0;
      flash_addr <= `CWL_WORD1_ADDR;
    end else if (dev_reset_req) begin
      state_q <= ST_FETCH1;
      word_one_q <= `CWL_ERASED_WORD;
      word_two_q <= `CWL_ERASED_WORD;
      flash_rd_en <= 1'b0;
      flash_addr <= `CWL_WORD1_ADDR;
    end else begin
      state_q <= state_d;
      flash_rd_en <= 1'b0;
      if (state_q == ST_FETCH1) begin
        flash_rd_en <= 1'b1;
        flash_addr <= `CWL_WORD1_ADDR;
      end
      if (state_q == ST_WAIT1 && flash_rvalid) begin
        word_one_q <= cwl_clean(flash_rdata);
        flash_rd_en <= 1'b1;
        flash_addr <= `CWL_WORD1_ADDR - `CWL_WORD_STEP;
      end
      if (state_q == ST_WAIT2 && flash_rvalid) begin
        word_two_q <= cwl_clean(flash_rdata);
      end
    end
  end

  // ****************************************************************
  // Output selection.
  // ****************************************************************

  assign core_reset_hold = (state_q != ST_DONE);
  assign active_word = core_reset_hold ? `CWL_ERASED_WORD : word_one_q;

  // Readable image of word one.
  always @* begin
    flash_config_word_one = active_word;
  end

  cwl_decode u_decode (
    .word(active_word),
    .scan_en(boundary_scan_port_enable),
    .code_prot_n(general_code_protect_n),
    .write_prot_n(general_write_protect_n),
    .run_mode(debug_mode_n),
    .pair_sel(emulator_pin_pair_select),
    .pair_rsvd(emulator_pair_reserved),
    .wdt_en(watchdog_enable_cfg),
    .win_dis(window_mode_disable),
    .prescale_ratio(watchdog_prescale_ratio),
    .post_sel(watchdog_postscale_select),
    .post_ratio_log(watchdog_postscale_log)
  );

  assign window_mode_active = watchdog_enable_cfg & ~window_mode_disable;

  // ****************************************************************
  // Table read port.
  // ****************************************************************

  assign in_cfg_space = (tbl_addr >= `CWL_CFG_SPACE_LO);
  assign shown_word = (tbl_addr == `CWL_CFG_BASE) ? flash_config_word_one :
                      (tbl_addr == `CWL_CFG_BASE + `CWL_WORD_STEP) ? word_two_q :
                      `CWL_ERASED_WORD;

  // Registered table answer, one cycle after the request.
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      tbl_rdata <= 24'h000000;
      tbl_hit <= 1'b0;
    end else begin
      tbl_hit <= tbl_rd_en & in_cfg_space;
      if (tbl_rd_en & in_cfg_space) begin
        tbl_rdata <= shown_word;
      end
    end
  end

endmodule // cwl_loader

`default_nettype wire

// *** bench/cwl_loader_sva.sv ***
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Checker on the loader ports.
// ****************************************************************
module cwl_loader_sva (
  // Clock, reset and requests
  input wire logic core_clk,
  input wire logic reset,
  input wire logic dev_reset_req,
  input wire logic flash_rd_en,
  input wire logic [23:0] flash_addr,
  input wire logic tbl_rd_en,
  input wire logic [23:0] tbl_addr,
  input wire logic [23:0] tbl_rdata,
  input wire logic tbl_hit,
  // Core release and decoded configuration
  input wire logic core_reset_hold,
  input wire logic boundary_scan_port_enable,
  input wire logic general_code_protect_n,
  input wire logic general_write_protect_n,
  input wire logic debug_mode_n,
  input wire logic [1:0] emulator_pin_pair_select,
  input wire logic emulator_pair_reserved,
  input wire logic watchdog_enable_cfg,
  input wire logic window_mode_disable,
  input wire logic window_mode_active,
  input wire logic [7:0] watchdog_prescale_ratio,
  input wire logic [3:0] watchdog_postscale_select,
  input wire logic [15:0] watchdog_postscale_log
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  // All decoded outputs in one bundle.
  wire [37:0] cfg = {boundary_scan_port_enable, general_code_protect_n, general_write_protect_n,
    debug_mode_n, emulator_pin_pair_select, emulator_pair_reserved, watchdog_enable_cfg,
    window_mode_disable, window_mode_active, watchdog_prescale_ratio,
    watchdog_postscale_select, watchdog_postscale_log};
  chk_erased_fetch: assert property (core_reset_hold |->
    cfg == {6'h3F, 1'b0, 2'h3, 1'b0, 8'h80, 4'hF, 16'h8000}) else $error("fetch not erased");
  chk_cfg_steady: assert property (!core_reset_hold && $past(!core_reset_hold) &&
    !dev_reset_req |-> $stable(cfg)) else $error("config moved");
  chk_reload_req: assert property (dev_reset_req |=> core_reset_hold) else $error("no reload");
  chk_rd_addr: assert property (flash_rd_en |->
    flash_addr == 24'h00ABFE || flash_addr == 24'h00ABFC) else $error("bad flash address");
  chk_tbl_space: assert property (tbl_rd_en |=>
    tbl_hit == ($past(tbl_addr) >= 24'h800000)) else $error("table hit wrong");
  chk_unimpl_ones: assert property (tbl_hit && $past(tbl_addr) == 24'hF80000 |->
    tbl_rdata[23:16] == 8'hFF && tbl_rdata[5]) else $error("unimplemented bits not one");
  chk_word_fields: assert property (tbl_hit && $past(tbl_addr) == 24'hF80000 &&
    !core_reset_hold |-> cfg[37:32] == {tbl_rdata[14:11], tbl_rdata[9:8]} &&
    cfg[30:29] == tbl_rdata[7:6] && cfg[27:20] == (tbl_rdata[4] ? 8'h80 : 8'h20))
    else $error("fields differ from word");
  chk_post_log: assert property (!core_reset_hold |->
    watchdog_postscale_log == 16'h0001 << watchdog_postscale_select) else $error("postscale");
  chk_window_pair: assert property (window_mode_active == (watchdog_enable_cfg &&
    !window_mode_disable) && emulator_pair_reserved == (emulator_pin_pair_select == 2'h0))
    else $error("window or pair flag wrong");
endmodule // cwl_loader_sva
bind cwl_loader cwl_loader_sva cwl_loader_sva_i (.*);
`default_nettype wire

// *** bench/cwl_flash_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Flash array holding the two configuration words.
// ****************************************************************
module cwl_flash_model #(parameter int LAT = 2) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Read port
  input wire logic flash_rd_en,
  input wire logic [23:0] flash_addr,
  output logic [23:0] flash_rdata,
  output logic flash_rvalid,
  // Stored words
  input wire logic [23:0] word_one,
  input wire logic [23:0] word_two
);
  logic [23:0] addr_q;
  int cnt_q;
  // word placement
  // Answers after LAT cycles; data toggles when not valid so nothing stale passes.
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cnt_q <= 0;
      flash_rvalid <= 1'b0;
      flash_rdata <= 24'h000000;
    end else begin
      flash_rvalid <= 1'b0;
      flash_rdata <= ~flash_rdata;
      if (flash_rd_en) begin
        addr_q <= flash_addr;
        cnt_q <= LAT;
      end else if (cnt_q > 0) begin
        cnt_q <= cnt_q - 1;
        if (cnt_q == 1) begin
          flash_rvalid <= 1'b1;
          flash_rdata <= (addr_q == 24'h00ABFE) ? word_one : word_two;
        end
      end
    end
  end
endmodule // cwl_flash_model
`default_nettype wire

// *** bench/cwl_loader_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module cwl_loader_tb;
  logic core_clk, reset, dev_reset_req, flash_rd_en, flash_rvalid, tbl_rd_en, tbl_hit;
  logic [23:0] flash_addr, flash_rdata, tbl_addr, tbl_rdata, word_one, word_two;
  logic core_reset_hold, boundary_scan_port_enable, general_code_protect_n, debug_mode_n;
  logic general_write_protect_n, emulator_pair_reserved, watchdog_enable_cfg;
  logic window_mode_disable, window_mode_active;
  logic [1:0] emulator_pin_pair_select;
  logic [7:0] watchdog_prescale_ratio;
  logic [3:0] watchdog_postscale_select;
  logic [15:0] watchdog_postscale_log;
  int bad_count, num_checks;
  // Word one beside its expected {reserved pair, window active} flags.
  logic [25:0] rows [5] = '{{24'hFFFFFF, 2'h0}, {24'h00A2D0, 2'h0}, {24'hFFD947, 2'h0},
    {24'hFF9C2A, 2'h2}, {24'hFFFF8F, 2'h1}};
  wire [37:0] cfg_vec = {boundary_scan_port_enable, general_code_protect_n,
    general_write_protect_n, debug_mode_n, emulator_pin_pair_select, emulator_pair_reserved,
    watchdog_enable_cfg, window_mode_disable, window_mode_active, watchdog_prescale_ratio,
    watchdog_postscale_select, watchdog_postscale_log};
  cwl_loader cwl_loader_i (.*);
  cwl_flash_model #(.LAT(3)) cwl_flash_model_i (.*);
  // Clock generation.
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // Compares one value and counts it.
  task chk(input string name, input logic [37:0] exp, input logic [37:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", name, exp, got);
      bad_count++;
    end
  endtask
  // Restarts the load and waits for the core release.
  task load(input logic [23:0] w);
    int i;
    @(posedge core_clk);
    word_one <= w;
    dev_reset_req <= 1'b1;
    @(posedge core_clk);
    dev_reset_req <= 1'b0;
    i = 0;
    do begin
      @(posedge core_clk);
      #1;
      i++;
    end while (core_reset_hold !== 1'b0 && i < 40);
    chk("hold", 38'h0, core_reset_hold);
  endtask
  // One table read with its expected answer.
  task tbl_rd(input logic [23:0] a, input logic h, input logic [23:0] d);
    @(posedge core_clk);
    tbl_rd_en <= 1'b1;
    tbl_addr <= a;
    @(posedge core_clk);
    tbl_rd_en <= 1'b0;
    #1;
    chk("hit", h, tbl_hit);
    if (h) chk("tbl", d, tbl_rdata);
  endtask
  // Prints counts and the verdict.
  task results;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #100000;
    bad_count++;
    results();
  end
  // Main sequence.
  initial begin
    logic [23:0] w;
    {reset, dev_reset_req, tbl_rd_en, tbl_addr} = {3'h4, 24'h000000};
    word_one = 24'hFFFFFF;
    word_two = 24'hFF5A3C;
    repeat (12) @(posedge core_clk);
    #1;
    chk("rst hold", 38'h1, core_reset_hold);
    reset <= 1'b0;
    for (int r = 0; r < 5; r++) begin
      w = rows[r][25:2];
      load(w);
      chk("cfg", {w[14:11], w[9:8], rows[r][1], w[7:6], rows[r][0], w[4] ? 8'h80 : 8'h20,
        w[3:0], 16'h0001 << w[3:0]}, cfg_vec);
      tbl_rd(24'hF80000, 1'b1, {8'hFF, w[15:6], 1'b1, w[4:0]});
    end
    tbl_rd(24'hF80002, 1'b1, word_two);
    tbl_rd(24'h7FFFFE, 1'b0, 24'h000000);
    tbl_rd(24'h800000, 1'b1, 24'hFFFFFF);
    reset <= 1'b1;
    @(posedge core_clk);
    reset <= 1'b0;
    load(24'hFF9C2A);
    chk("reload", {6'h0C, 1'b1, 2'h0, 1'b0, 8'h20, 4'hA, 16'h0400}, cfg_vec);
    results();
  end
endmodule // cwl_loader_tb
`default_nettype wire
